// >>> design/mcu_swap_skip_tableread_xor_exec.sv
// execution stage for nibble exchange, skip tests, table reads and xor
// assumes a synchronous data memory and ROM with one cycle read latency,
// and a decode stage on the same clock that holds its request until taken;
// a load of the accumulator from the core loses to an executing operation that writes acc
//
// Overview of operation
// - In-place exchange writes the byte back with its nibbles swapped.
// - Exchange to acc puts the swapped byte in acc, memory untouched.
// - Byte zero test flushes the prefetch and adds a dummy cycle on zero.
// - Load-and-test copies the byte to acc and skips likewise on zero.
// - Bit test skips with a dummy cycle when the chosen bit is clear.
// - Current-page read: low byte to memory, high bits to table high.
// - Last-page read does the same for a word in the top page.
// - Xor with memory leaves acc ^ byte in acc and moves only zero.
// - Xor to memory writes acc ^ byte back and moves only zero.
// - Xor immediate leaves acc ^ imm in acc and moves only zero.
module mcu_swap_skip_tableread_xor_exec
    import exec_pkg::*;
(
    input  wire logic                  MCLK,
    input  wire logic                  RESET,
    // request from the decode stage
    input  wire logic                  INSTR_VALID,
    input  wire logic [OP_W-1:0]       INSTR_OP,
    input  wire logic [ADDR_W-1:0]     INSTR_ADDR,
    input  wire logic [BIT_SEL_W-1:0]  INSTR_BIT,
    input  wire logic [DATA_W-1:0]     INSTR_IMM,
    input  wire logic [ROM_ADDR_W-1:0] INSTR_PC,
    output logic                       INSTR_READY,
    // accumulator load from the rest of the core
    input  wire logic                  ACC_LOAD,
    input  wire logic [DATA_W-1:0]     ACC_LOAD_DATA,
    // table pointer held elsewhere in the core
    input  wire logic [DATA_W-1:0]     TABLE_POINTER,
    // data memory port
    output logic                       MEM_RD_EN,
    output logic                       MEM_WR_EN,
    output logic [ADDR_W-1:0]          MEM_ADDR,
    output logic [DATA_W-1:0]          MEM_WR_DATA,
    input  wire logic [DATA_W-1:0]     MEM_RD_DATA,
    // program memory port
    output logic                       ROM_RD_EN,
    output logic [ROM_ADDR_W-1:0]      ROM_ADDR,
    input  wire logic [ROM_WORD_W-1:0] ROM_RD_DATA,
    // architectural state and pipeline control
    output logic [DATA_W-1:0]          ACC,
    output logic                       ZERO_FLAG,
    output logic [TBL_HI_W-1:0]        TABLE_HIGH_REGISTER,
    output logic                       DISCARD_NEXT,
    output logic                       DUMMY_CYCLE,
    output logic                       DONE
);

    // sequencer and the captured request
    state_e                  state_q;
    state_e                  state_d;
    logic [OP_W-1:0]         op_q;
    logic [ADDR_W-1:0]       addr_q;
    logic [BIT_SEL_W-1:0]    bit_q;
    logic [DATA_W-1:0]       imm_q;

    // registered strobes toward the two memories
    logic                    ready_q;
    logic                    mem_rd_q;
    logic                    mem_wr_q;
    logic [DATA_W-1:0]       mem_wdata_q;
    logic                    rom_rd_q;
    logic [ROM_ADDR_W-1:0]   rom_addr_q;
    logic [ROM_ADDR_W-1:0]   rom_addr_d;

    // architectural state and pipeline control
    logic [DATA_W-1:0]       acc_q;
    logic                    zero_q;
    logic [TBL_HI_W-1:0]     tbl_hi_q;
    logic                    discard_q;
    logic                    dummy_q;
    logic                    done_q;

    // request classification and operand path
    logic                    take;
    logic                    is_rom_op;
    logic                    is_imm_op;
    logic                    exec_rom;
    logic [DATA_W-1:0]       operand;
    logic [DATA_W-1:0]       result;
    logic                    write_mem;
    logic                    write_acc;
    logic                    write_zero;
    logic                    skip;
    logic                    in_exec;

    // a request is taken only while the sequencer is idle
    assign take    = INSTR_VALID & ready_q;
    assign in_exec = (state_q == S_EXEC);

    // classify the incoming operation by where its operand lives
    assign is_rom_op = (INSTR_OP == OP_ROM_READ_CURRENT_PAGE) |
                       (INSTR_OP == OP_ROM_READ_LAST_PAGE);
    assign is_imm_op = (INSTR_OP == OP_XOR_ACC_IMM);

    // table reads take their data from the ROM word, others from memory
    assign exec_rom = (op_q == OP_ROM_READ_CURRENT_PAGE) |
                      (op_q == OP_ROM_READ_LAST_PAGE);
    assign operand  = exec_rom ? ROM_RD_DATA[ROM_LO_MSB:0] : MEM_RD_DATA;

    // program address of the table word; pointer fills the low bits
    always_comb begin
        if (INSTR_OP == OP_ROM_READ_LAST_PAGE) begin
            rom_addr_d = {LAST_PAGE, TABLE_POINTER};
        end else begin
            rom_addr_d = {INSTR_PC[ROM_ADDR_W-1:PAGE_LSB],
                          TABLE_POINTER};
        end
    end

    operand_unit u_operand (
        .op         (op_q),
        .mem_byte   (operand),
        .acc        (acc_q),
        .imm        (imm_q),
        .bit_sel    (bit_q),
        .result     (result),
        .write_mem  (write_mem),
        .write_acc  (write_acc),
        .write_zero (write_zero),
        .skip       (skip)
    );

    // sequencer: read the operand, execute, and add a dummy on a skip
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (take) begin
                    // the immediate form has its operand and needs no read
                    if (is_rom_op) begin
                        state_d = S_ROM;
                    end else if (is_imm_op) begin
                        state_d = S_EXEC;
                    end else begin
                        state_d = S_READ;
                    end
                end
            end
            S_READ: begin
                state_d = S_EXEC;
            end
            S_ROM: begin
                state_d = S_EXEC;
            end
            S_EXEC: begin
                state_d = skip ? S_DUMMY : S_IDLE;
            end
            S_DUMMY: begin
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;                   // recover from a bad code
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ready is registered so the decode stage sees a clean level
    // a request offered while busy just waits; decode keeps holding it
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ready_q <= 1'b1;
        end else begin
            ready_q <= (state_d == S_IDLE);
        end
    end

    // capture the request fields once, so decode may move on
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            op_q   <= OP_NIBBLE_EXCHANGE;
            addr_q <= ADDR_RESET;
            bit_q  <= '0;
            imm_q  <= ACC_RESET;
        end else if (take) begin
            op_q   <= INSTR_OP;
            addr_q <= INSTR_ADDR;
            bit_q  <= INSTR_BIT;
            imm_q  <= INSTR_IMM;
        end
    end

    // data memory read strobe, one cycle long
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            mem_rd_q <= 1'b0;
        end else begin
            mem_rd_q <= take & ~is_rom_op & ~is_imm_op;
        end
    end

    // data memory write strobe and data, one cycle after execute
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            mem_wr_q    <= 1'b0;
            mem_wdata_q <= ACC_RESET;
        end else begin
            mem_wr_q <= in_exec & write_mem;
            if (in_exec & write_mem) begin
                mem_wdata_q <= result;
            end
        end
    end

    // program memory read strobe and address
    // the pointer is caught at take, so the core may move it afterwards
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rom_rd_q   <= 1'b0;
            rom_addr_q <= ROM_A_RESET;
        end else begin
            rom_rd_q <= take & is_rom_op;
            if (take & is_rom_op) begin
                rom_addr_q <= rom_addr_d;
            end
        end
    end

    // accumulator: an execute that writes acc wins over a load from the core in the same cycle
    // a core load is lost only if it lands on the execute edge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            acc_q <= ACC_RESET;
        end else if (in_exec & write_acc) begin
            acc_q <= result;
        end else if (ACC_LOAD) begin
            acc_q <= ACC_LOAD_DATA;
        end
    end

    // zero flag moves only for the xor forms
    // swaps, skips and table reads never touch it
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            zero_q <= 1'b0;
        end else if (in_exec & write_zero) begin
            zero_q <= (result == '0);
        end
    end

    // high part of the table word lands beside the memory write
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tbl_hi_q <= TBL_HI_RESET;
        end else if (in_exec & exec_rom) begin
            tbl_hi_q <=
                ROM_RD_DATA[ROM_WORD_W-1:ROM_HI_LSB];
        end
    end

    // skip handling: flush the prefetch and mark the dummy cycle in the same cycle
    // both pulses share one term so they can never come apart
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            discard_q <= 1'b0;
            dummy_q   <= 1'b0;
        end else begin
            discard_q <= in_exec & skip;
            dummy_q   <= in_exec & skip;
        end
    end

    // retire pulse: at the end of execute, or after the dummy cycle
    // a skip retires one cycle later; that cycle is the dummy
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (in_exec & ~skip) | (state_q == S_DUMMY);
        end
    end

    // every output comes straight from a flip-flop
    // the memory address holds between requests, so a late write still sees it
    assign INSTR_READY         = ready_q;
    assign MEM_RD_EN           = mem_rd_q;
    assign MEM_WR_EN           = mem_wr_q;
    assign MEM_ADDR            = addr_q;
    assign MEM_WR_DATA         = mem_wdata_q;
    assign ROM_RD_EN           = rom_rd_q;
    assign ROM_ADDR            = rom_addr_q;
    assign ACC                 = acc_q;
    assign ZERO_FLAG           = zero_q;
    assign TABLE_HIGH_REGISTER = tbl_hi_q;
    assign DISCARD_NEXT        = discard_q;
    assign DUMMY_CYCLE         = dummy_q;
    assign DONE                = done_q;

endmodule // mcu_swap_skip_tableread_xor_exec

// >>> design/operand_unit.sv
// result, write-back selection and skip decision for one operation
// assumes the operand byte, accumulator and immediate are stable inputs
module operand_unit
    import exec_pkg::*;
(
    input  wire logic [OP_W-1:0]      op,
    input  wire logic [DATA_W-1:0]    mem_byte,
    input  wire logic [DATA_W-1:0]    acc,
    input  wire logic [DATA_W-1:0]    imm,
    input  wire logic [BIT_SEL_W-1:0] bit_sel,
    output logic      [DATA_W-1:0]    result,
    output logic                      write_mem,
    output logic                      write_acc,
    output logic                      write_zero,
    output logic                      skip
);

    logic [DATA_W-1:0] swapped;

    // nibble exchange is shared by both exchange forms
    assign swapped = {mem_byte[NIB_LO_MSB:0], mem_byte[DATA_W-1:NIB_HI_LSB]};

    // pure decode; no operation here touches carry, overflow or half carry
    always_comb begin
        result     = mem_byte;
        write_mem  = 1'b0;
        write_acc  = 1'b0;
        write_zero = 1'b0;
        skip       = 1'b0;
        unique case (op)
            OP_NIBBLE_EXCHANGE: begin
                result    = swapped;
                write_mem = 1'b1;
            end
            OP_NIBBLE_EXCHANGE_TO_ACC: begin
                result    = swapped;
                write_acc = 1'b1;
            end
            OP_SKIP_IF_ZERO_TEST: begin
                skip = (mem_byte == '0);
            end
            OP_LOAD_TEST_SKIP: begin
                write_acc = 1'b1;
                skip      = (mem_byte == '0);
            end
            OP_BIT_SKIP_IF_CLEAR: begin
                skip = ~mem_byte[bit_sel];
            end
            OP_ROM_READ_CURRENT_PAGE, OP_ROM_READ_LAST_PAGE: begin
                write_mem = 1'b1;
            end
            OP_XOR_ACC_MEM: begin
                result     = acc ^ mem_byte;
                write_acc  = 1'b1;
                write_zero = 1'b1;
            end
            OP_EXCLUSIVE_OR_TO_MEMORY: begin
                result     = acc ^ mem_byte;
                write_mem  = 1'b1;
                write_zero = 1'b1;
            end
            OP_XOR_ACC_IMM: begin
                result     = acc ^ imm;
                write_acc  = 1'b1;
                write_zero = 1'b1;
            end
            default: begin
                result = mem_byte;                // unknown codes do nothing
            end
        endcase
    end

endmodule // operand_unit

// >>> pkg/exec_pkg.sv
// constants shared by the execution block and its operand unit
// assumes one 8-bit data path, a 14-bit program word and 2048-word ROM
package exec_pkg;

    // data path and program memory geometry
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int BIT_SEL_W  = 3;
    localparam int ROM_WORD_W = 14;
    localparam int ROM_ADDR_W = 11;
    localparam int PAGE_W     = 3;
    localparam int TBL_HI_W   = ROM_WORD_W - DATA_W;

    // field positions inside a program word, a program address and a data byte
    localparam int ROM_LO_MSB  = 7;
    localparam int ROM_HI_LSB  = 8;
    localparam int PAGE_LSB    = 8;
    localparam int NIB_HI_LSB  = 4;
    localparam int NIB_LO_MSB  = 3;

    // page that holds the top of program memory
    localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;

    // reset values
    localparam logic [DATA_W-1:0]     ACC_RESET    = 8'h00;
    localparam logic [TBL_HI_W-1:0]   TBL_HI_RESET = 6'h00;
    localparam logic [ADDR_W-1:0]     ADDR_RESET   = 8'h00;
    localparam logic [ROM_ADDR_W-1:0] ROM_A_RESET  = 11'h000;

    // operation codes presented by the decode stage
    localparam int OP_W = 4;
    typedef logic [OP_W-1:0] op_t;
    localparam op_t OP_NIBBLE_EXCHANGE        = 4'h0;
    localparam op_t OP_NIBBLE_EXCHANGE_TO_ACC = 4'h1;
    localparam op_t OP_SKIP_IF_ZERO_TEST      = 4'h2;
    localparam op_t OP_LOAD_TEST_SKIP         = 4'h3;
    localparam op_t OP_BIT_SKIP_IF_CLEAR      = 4'h4;
    localparam op_t OP_ROM_READ_CURRENT_PAGE  = 4'h5;
    localparam op_t OP_ROM_READ_LAST_PAGE     = 4'h6;
    localparam op_t OP_XOR_ACC_MEM            = 4'h7;
    localparam op_t OP_EXCLUSIVE_OR_TO_MEMORY = 4'h8;
    localparam op_t OP_XOR_ACC_IMM            = 4'h9;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_READ  = 5'b00010,
        S_ROM   = 5'b00100,
        S_EXEC  = 5'b01000,
        S_DUMMY = 5'b10000
    } state_e;

endpackage

// >>> tb/exec_monitor.sv
// concurrent checks on the execution block, seen from its top ports
// assumes memories answer one cycle after each read strobe
module exec_monitor
    import exec_pkg::*;
(
    input wire logic                  MCLK,
    input wire logic                  RESET,
    input wire logic                  INSTR_VALID,
    input wire logic [OP_W-1:0]       INSTR_OP,
    input wire logic [BIT_SEL_W-1:0]  INSTR_BIT,
    input wire logic [DATA_W-1:0]     INSTR_IMM,
    input wire logic [ROM_ADDR_W-1:0] INSTR_PC,
    input wire logic                  INSTR_READY,
    input wire logic [DATA_W-1:0]     TABLE_POINTER,
    input wire logic                  MEM_WR_EN,
    input wire logic [DATA_W-1:0]     MEM_WR_DATA,
    input wire logic [DATA_W-1:0]     MEM_RD_DATA,
    input wire logic                  ROM_RD_EN,
    input wire logic [ROM_ADDR_W-1:0] ROM_ADDR,
    input wire logic [ROM_WORD_W-1:0] ROM_RD_DATA,
    input wire logic [DATA_W-1:0]     ACC,
    input wire logic                  ZERO_FLAG,
    input wire logic [TBL_HI_W-1:0]   TABLE_HIGH_REGISTER,
    input wire logic                  DISCARD_NEXT,
    input wire logic                  DUMMY_CYCLE,
    input wire logic                  DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    // slices held in nets so that past values can be taken of them
    wire logic [PAGE_W-1:0]   pc_page = INSTR_PC[10:8];
    wire logic [DATA_W-1:0]   rd_swap = {MEM_RD_DATA[3:0], MEM_RD_DATA[7:4]};
    wire logic [DATA_W-1:0]   rom_lo  = ROM_RD_DATA[7:0];
    wire logic [TBL_HI_W-1:0] rom_hi  = ROM_RD_DATA[13:8];
    wire logic                rom_op  = INSTR_OP == OP_ROM_READ_CURRENT_PAGE
                                     || INSTR_OP == OP_ROM_READ_LAST_PAGE;

    // a take, then the third edge where operand results show
    sequence after_read(op_t o);
        INSTR_VALID && INSTR_READY && INSTR_OP == o ##3 1'b1;
    endsequence
    sequence rom_take;
        INSTR_VALID && INSTR_READY && rom_op;
    endsequence

    swap_write_a: assert property (
        after_read(OP_NIBBLE_EXCHANGE) |-> DONE && MEM_WR_EN
        && MEM_WR_DATA == $past(rd_swap) && $stable(ZERO_FLAG))
        else $error("in-place swap wrong");
    swap_acc_a: assert property (
        after_read(OP_NIBBLE_EXCHANGE_TO_ACC) |-> DONE && !MEM_WR_EN
        && ACC == $past(rd_swap) && $stable(ZERO_FLAG))
        else $error("swap into acc wrong");
    zero_skip_a: assert property (
        after_read(OP_SKIP_IF_ZERO_TEST)
        |-> DISCARD_NEXT == ($past(MEM_RD_DATA) == 8'h00) && !MEM_WR_EN)
        else $error("byte test skip wrong");
    load_test_a: assert property (
        after_read(OP_LOAD_TEST_SKIP) |-> ACC == $past(MEM_RD_DATA)
        && DISCARD_NEXT == ($past(MEM_RD_DATA) == 8'h00))
        else $error("load and test wrong");
    bit_skip_a: assert property (
        after_read(OP_BIT_SKIP_IF_CLEAR) |-> DISCARD_NEXT ==
        ((($past(MEM_RD_DATA) >> $past(INSTR_BIT, 3)) & 8'h01) == 8'h00))
        else $error("bit test skip wrong");
    skip_done_a: assert property (
        DISCARD_NEXT |-> DUMMY_CYCLE && !DONE
        ##1 DONE && INSTR_READY && $stable(ZERO_FLAG))
        else $error("dummy cycle wrong");
    rom_addr_a: assert property (
        rom_take |=> ROM_RD_EN && ROM_ADDR ==
        {($past(INSTR_OP) == OP_ROM_READ_LAST_PAGE) ? LAST_PAGE
        : $past(pc_page), $past(TABLE_POINTER)})
        else $error("table address wrong");
    table_store_a: assert property (
        rom_take ##3 1'b1 |-> DONE && MEM_WR_EN
        && MEM_WR_DATA == $past(rom_lo)
        && TABLE_HIGH_REGISTER == $past(rom_hi))
        else $error("table store wrong");
    xor_mem_a: assert property (
        after_read(OP_XOR_ACC_MEM) |-> DONE
        && ACC == ($past(ACC) ^ $past(MEM_RD_DATA))
        && ZERO_FLAG == (ACC == 8'h00))
        else $error("xor into acc wrong");
    xor_store_a: assert property (
        after_read(OP_EXCLUSIVE_OR_TO_MEMORY) |-> DONE && MEM_WR_EN
        && MEM_WR_DATA == ($past(ACC) ^ $past(MEM_RD_DATA))
        && ZERO_FLAG == (MEM_WR_DATA == 8'h00))
        else $error("xor into memory wrong");
    xor_imm_a: assert property (
        INSTR_VALID && INSTR_READY && INSTR_OP == OP_XOR_ACC_IMM
        |-> ##2 DONE && ACC == ($past(ACC) ^ $past(INSTR_IMM, 2))
        && ZERO_FLAG == (ACC == 8'h00))
        else $error("xor immediate wrong");
    zero_hold_a: assert property (
        !DONE |-> $stable(ZERO_FLAG))
        else $error("zero flag moved");
endmodule // exec_monitor

bind mcu_swap_skip_tableread_xor_exec exec_monitor u_mon (
    .MCLK(MCLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
    .INSTR_OP(INSTR_OP), .INSTR_BIT(INSTR_BIT), .INSTR_IMM(INSTR_IMM),
    .INSTR_PC(INSTR_PC), .INSTR_READY(INSTR_READY),
    .TABLE_POINTER(TABLE_POINTER), .MEM_WR_EN(MEM_WR_EN),
    .MEM_WR_DATA(MEM_WR_DATA), .MEM_RD_DATA(MEM_RD_DATA),
    .ROM_RD_EN(ROM_RD_EN), .ROM_ADDR(ROM_ADDR), .ROM_RD_DATA(ROM_RD_DATA),
    .ACC(ACC), .ZERO_FLAG(ZERO_FLAG),
    .TABLE_HIGH_REGISTER(TABLE_HIGH_REGISTER),
    .DISCARD_NEXT(DISCARD_NEXT), .DUMMY_CYCLE(DUMMY_CYCLE), .DONE(DONE));

// >>> tb/testbench.sv
// self-checking bench for the execution block with memory stand-ins
// assumes one-cycle synchronous data memory and program memory
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;

    logic                  clk, rst, vld, ld, rdy, mrd, mwr, rrd;
    logic                  zf, disc, dum, done;
    logic [OP_W-1:0]       op;
    logic [BIT_SEL_W-1:0]  bsel;
    logic [DATA_W-1:0]     addr, imm, ld_d, tp, ma, mwd, mrdd, acc;
    logic [ROM_ADDR_W-1:0] pc, ra;
    logic [ROM_WORD_W-1:0] rrdd, w;
    logic [TBL_HI_W-1:0]   th;
    logic [DATA_W-1:0]     mem [256];
    int                    mismatches, num_checks, ncyc;

    mcu_swap_skip_tableread_xor_exec dut (
        .MCLK(clk), .RESET(rst), .INSTR_VALID(vld), .INSTR_OP(op),
        .INSTR_ADDR(addr), .INSTR_BIT(bsel), .INSTR_IMM(imm), .INSTR_PC(pc),
        .INSTR_READY(rdy), .ACC_LOAD(ld), .ACC_LOAD_DATA(ld_d),
        .TABLE_POINTER(tp), .MEM_RD_EN(mrd), .MEM_WR_EN(mwr), .MEM_ADDR(ma),
        .MEM_WR_DATA(mwd), .MEM_RD_DATA(mrdd), .ROM_RD_EN(rrd),
        .ROM_ADDR(ra), .ROM_RD_DATA(rrdd), .ACC(acc), .ZERO_FLAG(zf),
        .TABLE_HIGH_REGISTER(th), .DISCARD_NEXT(disc), .DUMMY_CYCLE(dum),
        .DONE(done));

    // program word pattern, distinct per page so a wrong page shows
    function automatic logic [ROM_WORD_W-1:0] rom_f(input logic [10:0] a);
        return {a[10:8] ^ 3'h5, a[2:0], a[7:0] ^ 8'h96};
    endfunction

    // memories answer one cycle after a strobe; idle lines scramble
    always @(posedge clk) begin
        mrdd <= mrd ? mem[ma] : ~mrdd;
        rrdd <= rrd ? rom_f(ra) : ~rrdd;
        if (mwr)
            mem[ma] <= mwd;
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_n(input int g, input int e);
        num_checks++;
        if (g != e) begin
            mismatches++;
            $display("[ERR] %0t cycles %0d expected %0d", $time, g, e);
        end
    endtask

    // one request held until taken, then cycles counted up to retire
    task automatic run(input op_t o, input logic [7:0] a, x,
                       input logic [10:0] p);
        int k;
        @(posedge clk);
        vld <= 1'b1;
        op <= o;
        addr <= a;
        imm <= x;
        bsel <= x[2:0];
        pc <= p;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        @(posedge clk);
        vld <= 1'b0;
        ncyc = 0;
        do begin
            @(negedge clk);
            ncyc++;
        end while (done !== 1'b1 && ncyc < 20);
        if (k >= 20 || ncyc >= 20) begin
            mismatches++;
            $display("[ERR] %0t request never retired", $time);
            end_sim();
        end
    endtask

    task automatic load(input logic [7:0] d);
        @(posedge clk);
        ld <= 1'b1;
        ld_d <= d;
        @(posedge clk);
        ld <= 1'b0;
    endtask

    task automatic t_xor;
        mem[8'h40] = 8'h0f;
        mem[8'h41] = 8'hf0;
        load(8'h0f);
        run(OP_XOR_ACC_MEM, 8'h40, 8'h00, 11'h000);
        chk_b(acc, 8'h00);
        chk_b({7'h0, zf}, 8'h01);
        load(8'h0c);
        run(OP_EXCLUSIVE_OR_TO_MEMORY, 8'h41, 8'h00, 11'h000);
        @(negedge clk);
        chk_b(mem[8'h41], 8'hfc);
        chk_b({7'h0, zf}, 8'h00);
        run(OP_XOR_ACC_IMM, 8'h00, 8'h0c, 11'h000);
        chk_n(ncyc, 2);
        chk_b(acc, 8'h00);
        chk_b({7'h0, zf}, 8'h01);
    endtask

    task automatic t_swap;
        mem[8'h10] = 8'h3c;
        mem[8'h21] = 8'h5a;
        run(OP_NIBBLE_EXCHANGE, 8'h10, 8'h00, 11'h000);
        @(negedge clk);
        chk_b(mem[8'h10], 8'hc3);
        run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h21, 8'h00, 11'h000);
        @(negedge clk);
        chk_b(acc, 8'ha5);
        chk_b(mem[8'h21], 8'h5a);
        chk_b({7'h0, zf}, 8'h01);
    endtask

    // zero and non-zero operands, then every bit position of one byte
    task automatic t_skip;
        logic [7:0] pat;
        pat = 8'ha5;
        mem[8'h50] = 8'h00;
        mem[8'h51] = 8'h80;
        mem[8'h52] = pat;
        run(OP_SKIP_IF_ZERO_TEST, 8'h50, 8'h00, 11'h000);
        chk_n(ncyc, 4);
        run(OP_SKIP_IF_ZERO_TEST, 8'h51, 8'h00, 11'h000);
        chk_n(ncyc, 3);
        run(OP_LOAD_TEST_SKIP, 8'h50, 8'h00, 11'h000);
        chk_n(ncyc, 4);
        chk_b(acc, 8'h00);
        run(OP_LOAD_TEST_SKIP, 8'h51, 8'h00, 11'h000);
        chk_n(ncyc, 3);
        chk_b(acc, 8'h80);
        for (int i = 0; i < 8; i++) begin
            run(OP_BIT_SKIP_IF_CLEAR, 8'h52, 8'(i), 11'h000);
            chk_n(ncyc, pat[i] ? 3 : 4);
        end
        chk_b({7'h0, zf}, 8'h01);
    endtask

    // pointer gives low bits, page from pc or the top page
    task automatic t_table;
        @(posedge clk);
        tp <= 8'h7e;
        run(OP_ROM_READ_CURRENT_PAGE, 8'h30, 8'h00, 11'h3f0);
        @(negedge clk);
        w = rom_f({3'h3, 8'h7e});
        chk_b(mem[8'h30], w[7:0]);
        chk_b({2'h0, th}, {2'h0, w[13:8]});
        @(posedge clk);
        tp <= 8'h01;
        run(OP_ROM_READ_LAST_PAGE, 8'h31, 8'h00, 11'h3f0);
        @(negedge clk);
        w = rom_f({LAST_PAGE, 8'h01});
        chk_b(mem[8'h31], w[7:0]);
        chk_b({2'h0, th}, {2'h0, w[13:8]});
    endtask

    // a second reset in mid-run must clear acc and the table high bits and leave ready set
    task automatic t_reset;
        load(8'h77);
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_b(acc, 8'h00);
        chk_b({1'b0, rdy, th}, 8'h40);
    endtask

    initial begin
        rst = 1'b1;
        vld = 1'b0;
        op = 4'h0;
        addr = 8'h00;
        bsel = 3'h0;
        imm = 8'h00;
        pc = 11'h000;
        ld = 1'b0;
        ld_d = 8'h00;
        tp = 8'h00;
        mrdd = 8'h00;
        rrdd = 14'h0000;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_xor();
        t_swap();
        t_skip();
        t_table();
        t_reset();
        end_sim();
    end
endmodule // testbench
